/* File: rtl/slrs_align_monitor.sv */
// Initial lane alignment watcher: live flags, sticky failure, sync request.
`timescale 1ns/100ps
module slrs_align_monitor
    import slrs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [LANES-1:0] lane_ok,
    input wire logic clear_fail,
    output logic [LANES-1:0] lane_align_sync_bits,
    output logic align_fail_event,
    output logic align_lost
);

    typedef struct packed {
        logic [LANES-1:0] live;
        logic fail;
        logic lost;
    } slrs_align_state_type;

    slrs_align_state_type st_q;
    slrs_align_state_type st_d;
    logic [LANES-1:0] drop;

    always_comb begin
        st_d = st_q;
        drop = st_q.live & ~lane_ok;
        st_d.live = lane_ok;
        if (clear_fail) begin
            st_d.fail = 1'b0;
        end
        // A lane that drops after being aligned counts as a failure
        if (slrs_any_lane(drop)) begin
            st_d.fail = 1'b1;
        end
        st_d.lost = slrs_any_lane(~lane_ok);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            // No lane is aligned out of reset, so the request must stand from the start
            st_q <= '{live: '0, fail: 1'b0, lost: 1'b1};
        end else begin
            st_q <= st_d;
        end
    end

    assign lane_align_sync_bits = st_q.live;
    assign align_fail_event = st_q.fail;
    assign align_lost = st_q.lost;

endmodule : slrs_align_monitor

/* File: rtl/slrs_err_summary.sv */
// Error threshold summary per lane and per error kind.
`timescale 1ns/100ps
module slrs_err_summary
    import slrs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [LANES-1:0] disparity_lanes,
    input wire logic [LANES-1:0] invalid_code_lanes,
    input wire logic [LANES-1:0] stray_control_lanes,
    output logic [LANES-1:0] disparity_lanes_q,
    output logic [LANES-1:0] invalid_code_lanes_q,
    output logic [LANES-1:0] stray_control_lanes_q,
    output slrs_err_flags_type err_flags
);

    typedef struct packed {
        logic [LANES-1:0] disp;
        logic [LANES-1:0] code;
        logic [LANES-1:0] ctrl;
        slrs_err_flags_type flags;
    } slrs_err_state_type;

    slrs_err_state_type st_q;
    slrs_err_state_type st_d;

    always_comb begin
        st_d = st_q;
        st_d.disp = disparity_lanes;
        st_d.code = invalid_code_lanes;
        st_d.ctrl = stray_control_lanes;
        st_d.flags.disparity = slrs_any_lane(disparity_lanes);
        st_d.flags.invalid_code = slrs_any_lane(invalid_code_lanes);
        st_d.flags.stray_control = slrs_any_lane(stray_control_lanes);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign disparity_lanes_q = st_q.disp;
    assign invalid_code_lanes_q = st_q.code;
    assign stray_control_lanes_q = st_q.ctrl;
    assign err_flags = st_q.flags;

endmodule : slrs_err_summary

/* File: rtl/slrs_pkg.sv */
// Shared constants and carrier types for the receive link status block.
package slrs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register addresses
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] ADDR_DISP_LANES = 12'h46D;
    localparam logic [ADDR_W-1:0] ADDR_CODE_LANES = 12'h46E;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_LANES = 12'h46F;
    localparam logic [ADDR_W-1:0] ADDR_LANE_INIT_SYNC_FLAGS = 12'h473;
    localparam logic [ADDR_W-1:0] ADDR_FRAME_OCTET_COUNT = 12'h476;
    localparam logic [ADDR_W-1:0] ADDR_LINK_TEST_CONTROL = 12'h477;
    localparam logic [ADDR_W-1:0] ADDR_ALIGNMENT_MULTIFRAME_COUNT = 12'h478;
    localparam logic [ADDR_W-1:0] ADDR_INTERRUPT_VECTOR = 12'h47A;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int LANES = 8;
    localparam int BIT_ALIGN_IRQ_CLEAR = 7;
    localparam int BIT_TEST_MODE = 7;
    localparam int BIT_THRESH_MASK_EN = 3;
    localparam int BIT_DISPARITY = 7;
    localparam int BIT_INVALID_CODE = 6;
    localparam int BIT_STRAY_CONTROL = 5;
    localparam int BIT_ALIGN_FAIL = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] RST_LANE_INIT_SYNC_FLAGS = 8'h00;
    localparam logic [7:0] RST_FRAME_OCTET_COUNT = 8'h01;
    localparam logic [7:0] RST_LINK_TEST_CONTROL = 8'h00;
    localparam logic [7:0] RST_ALIGNMENT_MULTIFRAME_COUNT = 8'h01;
    localparam logic [7:0] RST_INTERRUPT_VECTOR = 8'h00;
    localparam logic [7:0] RD_ZERO = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Valid frame sizes
    localparam logic [7:0] OCTETS_ONE = 8'h01;
    localparam logic [7:0] OCTETS_TWO = 8'h02;
    localparam logic [7:0] OCTETS_FOUR = 8'h04;

    ////////////////////////////////////////////////////////////////////////////
    // Carrier types
    typedef struct packed {
        logic [LANES-1:0] align_ok;
        logic [LANES-1:0] disparity;
        logic [LANES-1:0] invalid_code;
        logic [LANES-1:0] stray_control;
    } slrs_lane_status_type;

    typedef struct packed {
        logic disparity;
        logic invalid_code;
        logic stray_control;
    } slrs_err_flags_type;

    typedef struct packed {
        logic [7:0] octets_per_frame;
        logic octets_valid;
        logic alignment_test_mode;
        logic threshold_mask_en;
        logic [7:0] alignment_multiframes;
    } slrs_link_cfg_type;

    function automatic logic slrs_any_lane(input logic [LANES-1:0] v);
        return |v;
    endfunction : slrs_any_lane

endpackage : slrs_pkg

/* File: rtl/slrs_top.sv */
// Receive link status, configuration and interrupt vector top level.
`timescale 1ns/100ps
module slrs_top
    import slrs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rd_valid,
    input wire slrs_lane_status_type lane_status,
    input wire logic [2:0] sync_assert_mask,
    output slrs_link_cfg_type link_cfg,
    output logic sync_request_out,
    output logic irq_n
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [7:0] octets_per_frame;
        logic alignment_test_mode;
        logic threshold_mask_en;
        logic [7:0] alignment_multiframes;
        logic disparity_err_irq_en;
        logic invalid_code_irq_en;
        logic stray_control_irq_en;
        logic align_fail_irq_en;
        logic [7:0] rdata;
        logic rd_valid;
        logic sync_req;
        logic irq_n;
    } slrs_top_state_type;

    slrs_top_state_type st_q;
    slrs_top_state_type st_d;

    logic [LANES-1:0] lane_align_sync_bits;
    logic align_fail_event;
    logic align_lost;
    logic clear_fail;
    logic [LANES-1:0] disp_lanes;
    logic [LANES-1:0] code_lanes;
    logic [LANES-1:0] ctrl_lanes;
    slrs_err_flags_type err_flags;
    logic [7:0] vector_rd;
    logic [7:0] rd_mux;
    logic irq_any;
    logic sync_err;

    function automatic logic slrs_hit(input logic en, input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] ref_a);
        return en && (a == ref_a);
    endfunction : slrs_hit

    function automatic logic slrs_size_ok(input logic [7:0] v);
        return (v == OCTETS_ONE) || (v == OCTETS_TWO) || (v == OCTETS_FOUR);
    endfunction : slrs_size_ok

    ////////////////////////////////////////////////////////////////////////////
    // Submodules

    assign clear_fail = slrs_hit(reg_wr_en, reg_addr, ADDR_LANE_INIT_SYNC_FLAGS)
                        && reg_wdata[BIT_ALIGN_IRQ_CLEAR];

    slrs_align_monitor u_align (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .lane_ok(lane_status.align_ok),
        .clear_fail(clear_fail),
        .lane_align_sync_bits(lane_align_sync_bits),
        .align_fail_event(align_fail_event),
        .align_lost(align_lost)
    );

    slrs_err_summary u_err (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .disparity_lanes(lane_status.disparity),
        .invalid_code_lanes(lane_status.invalid_code),
        .stray_control_lanes(lane_status.stray_control),
        .disparity_lanes_q(disp_lanes),
        .invalid_code_lanes_q(code_lanes),
        .stray_control_lanes_q(ctrl_lanes),
        .err_flags(err_flags)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Readback and interrupt terms

    always_comb begin
        vector_rd = RD_ZERO;
        vector_rd[BIT_DISPARITY] = err_flags.disparity;
        vector_rd[BIT_INVALID_CODE] = err_flags.invalid_code;
        vector_rd[BIT_STRAY_CONTROL] = err_flags.stray_control;
        vector_rd[BIT_ALIGN_FAIL] = align_fail_event;
    end

    always_comb begin
        rd_mux = RD_ZERO;
        case (reg_addr)
            ADDR_DISP_LANES: begin
                rd_mux = disp_lanes;
            end
            ADDR_CODE_LANES: begin
                rd_mux = code_lanes;
            end
            ADDR_CTRL_LANES: begin
                rd_mux = ctrl_lanes;
            end
            ADDR_LANE_INIT_SYNC_FLAGS: begin
                rd_mux = lane_align_sync_bits;
            end
            ADDR_FRAME_OCTET_COUNT: begin
                rd_mux = st_q.octets_per_frame;
            end
            ADDR_LINK_TEST_CONTROL: begin
                rd_mux[BIT_TEST_MODE] = st_q.alignment_test_mode;
                rd_mux[BIT_THRESH_MASK_EN] = st_q.threshold_mask_en;
            end
            ADDR_ALIGNMENT_MULTIFRAME_COUNT: begin
                rd_mux = st_q.alignment_multiframes;
            end
            // Masks are write-only, so reads return the flags
            ADDR_INTERRUPT_VECTOR: begin
                rd_mux = vector_rd;
            end
            default: begin
                rd_mux = RD_ZERO;
            end
        endcase
    end

    assign irq_any = (st_q.disparity_err_irq_en && err_flags.disparity)
                     || (st_q.invalid_code_irq_en && err_flags.invalid_code)
                     || (st_q.stray_control_irq_en && err_flags.stray_control)
                     || (st_q.align_fail_irq_en && align_fail_event);

    assign sync_err = st_q.threshold_mask_en
                      && ((sync_assert_mask[2] && err_flags.disparity)
                          || (sync_assert_mask[1] && err_flags.invalid_code)
                          || (sync_assert_mask[0] && err_flags.stray_control));

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_d = st_q;
        st_d.rd_valid = reg_rd_en;
        if (reg_rd_en) begin
            st_d.rdata = rd_mux;
        end
        if (reg_wr_en) begin
            case (reg_addr)
                ADDR_FRAME_OCTET_COUNT: begin
                    st_d.octets_per_frame = reg_wdata;
                end
                ADDR_LINK_TEST_CONTROL: begin
                    st_d.alignment_test_mode = reg_wdata[BIT_TEST_MODE];
                    st_d.threshold_mask_en = reg_wdata[BIT_THRESH_MASK_EN];
                end
                ADDR_ALIGNMENT_MULTIFRAME_COUNT: begin
                    st_d.alignment_multiframes = reg_wdata;
                end
                ADDR_INTERRUPT_VECTOR: begin
                    st_d.disparity_err_irq_en = reg_wdata[BIT_DISPARITY];
                    st_d.invalid_code_irq_en = reg_wdata[BIT_INVALID_CODE];
                    st_d.stray_control_irq_en = reg_wdata[BIT_STRAY_CONTROL];
                    st_d.align_fail_irq_en = reg_wdata[BIT_ALIGN_FAIL];
                end
                default: begin
                    st_d.rd_valid = st_d.rd_valid;
                end
            endcase
        end
        st_d.sync_req = align_lost || sync_err;
        // Registered so the pin cannot glitch on mask writes
        st_d.irq_n = ~irq_any;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q.octets_per_frame <= RST_FRAME_OCTET_COUNT;
            st_q.alignment_test_mode <= RST_LINK_TEST_CONTROL[BIT_TEST_MODE];
            st_q.threshold_mask_en <= RST_LINK_TEST_CONTROL[BIT_THRESH_MASK_EN];
            st_q.alignment_multiframes <= RST_ALIGNMENT_MULTIFRAME_COUNT;
            st_q.disparity_err_irq_en <= RST_INTERRUPT_VECTOR[BIT_DISPARITY];
            st_q.invalid_code_irq_en <= RST_INTERRUPT_VECTOR[BIT_INVALID_CODE];
            st_q.stray_control_irq_en <= RST_INTERRUPT_VECTOR[BIT_STRAY_CONTROL];
            st_q.align_fail_irq_en <= RST_INTERRUPT_VECTOR[BIT_ALIGN_FAIL];
            st_q.rdata <= RD_ZERO;
            st_q.rd_valid <= 1'b0;
            st_q.sync_req <= 1'b1;
            st_q.irq_n <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    always_comb begin
        link_cfg.octets_per_frame = st_q.octets_per_frame;
        link_cfg.octets_valid = slrs_size_ok(st_q.octets_per_frame);
        link_cfg.alignment_test_mode = st_q.alignment_test_mode;
        link_cfg.threshold_mask_en = st_q.threshold_mask_en;
        link_cfg.alignment_multiframes = st_q.alignment_multiframes;
    end

    assign reg_rdata = st_q.rdata;
    assign reg_rd_valid = st_q.rd_valid;
    assign sync_request_out = st_q.sync_req;
    assign irq_n = st_q.irq_n;

endmodule : slrs_top

/* File: verification/slrs_chk.sv */
// Checker: port-level assertions for the link status block.
`timescale 1ns/100ps
module slrs_chk
    import slrs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_valid,
    input wire slrs_lane_status_type lane_status,
    input wire logic [2:0] sync_assert_mask,
    input wire slrs_link_cfg_type link_cfg,
    input wire logic sync_request_out,
    input wire logic irq_n
);
    logic [7:0] msk_q;
    // Masks are write-only, so they are shadowed here
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            msk_q <= 8'h00;
        end else if (reg_wr_en && reg_addr == ADDR_INTERRUPT_VECTOR) begin
            msk_q <= reg_wdata;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////
    property p_flags;
        reg_rd_en && reg_addr == ADDR_LANE_INIT_SYNC_FLAGS |=>
            reg_rdata == $past(lane_status.align_ok, 2);
    endproperty
    a_flags: assert property (p_flags) else $error("lane flag readback");
    property p_loss;
        lane_status.align_ok != 8'hFF |-> ##2 sync_request_out;
    endproperty
    a_loss: assert property (p_loss) else $error("no sync request");
    property p_fsize;
        link_cfg.octets_valid == (link_cfg.octets_per_frame inside {8'h01, 8'h02, 8'h04});
    endproperty
    a_fsize: assert property (p_fsize) else $error("frame size valid");
    property p_mode;
        reg_wr_en && reg_addr == ADDR_LINK_TEST_CONTROL |=>
            link_cfg.alignment_test_mode == $past(reg_wdata[7]);
    endproperty
    a_mode: assert property (p_mode) else $error("test mode bit");
    property p_kmf;
        reg_wr_en && reg_addr == ADDR_ALIGNMENT_MULTIFRAME_COUNT |=>
            link_cfg.alignment_multiframes == $past(reg_wdata);
    endproperty
    a_kmf: assert property (p_kmf) else $error("multiframe count");
    property p_vec;
        reg_rd_en && reg_addr == ADDR_INTERRUPT_VECTOR |=>
            reg_rdata[7] == ($past(lane_status.disparity, 2) != 8'h00)
            && reg_rdata[6] == ($past(lane_status.invalid_code, 2) != 8'h00)
            && reg_rdata[5] == ($past(lane_status.stray_control, 2) != 8'h00);
    endproperty
    a_vec: assert property (p_vec) else $error("vector error flags");
    property p_rsvd;
        reg_rd_en && reg_addr == ADDR_INTERRUPT_VECTOR |=>
            reg_rdata[4] == 1'b0 && reg_rdata[2:0] == 3'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("vector reserved bits");
    property p_lanes;
        reg_rd_en && reg_addr == ADDR_DISP_LANES |=>
            reg_rdata == $past(lane_status.disparity, 2);
    endproperty
    a_lanes: assert property (p_lanes) else $error("per-lane view");
    property p_irq_err;
        (lane_status.disparity != 8'h00) ##1 msk_q[7] |-> ##1 !irq_n;
    endproperty
    a_irq_err: assert property (p_irq_err) else $error("error irq");
    property p_irq_fail;
        (($past(lane_status.align_ok) & ~lane_status.align_ok) != 8'h00) ##1 msk_q[3]
            |-> ##1 !irq_n;
    endproperty
    a_irq_fail: assert property (p_irq_fail) else $error("align irq");
    property p_sync_err;
        (lane_status.disparity != 8'h00) ##1 (sync_assert_mask[2] && link_cfg.threshold_mask_en)
            |-> ##1 sync_request_out;
    endproperty
    a_sync_err: assert property (p_sync_err) else $error("error sync");
    // Read valid follows the strobe one edge later, for as long as the strobe stands
    property p_rdv;
        reg_rd_valid == $past(reg_rd_en);
    endproperty
    a_rdv: assert property (p_rdv) else $error("read valid timing");
    c_irq: cover property (!irq_n);
    c_read: cover property (reg_rd_valid);
    c_sync: cover property ($fell(sync_request_out));
endmodule : slrs_chk
bind slrs_top slrs_chk slrs_chk_inst (.core_clk, .rst_n, .reg_wr_en, .reg_rd_en, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_rd_valid, .lane_status, .sync_assert_mask, .link_cfg,
    .sync_request_out, .irq_n);

/* File: verification/slrs_tx_model.sv */
// Transmitter stand-in: presents lane status, counts sync request cycles.
`timescale 1ns/100ps
module slrs_tx_model
    import slrs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire slrs_lane_status_type lane_cmd,
    input wire logic sync_request_out,
    output slrs_lane_status_type lane_status,
    output int sync_cycles
);
    // Status is a level, so it follows the command with no delay
    assign lane_status = lane_cmd;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_cycles <= 0;
        end else if (sync_request_out) begin
            sync_cycles <= sync_cycles + 1;
        end
    end
endmodule : slrs_tx_model

/* File: verification/testbench.sv */
// Testbench: register and status scenarios for the link status block.
`timescale 1ns/100ps
module testbench
    import slrs_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [ADDR_W-1:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic [2:0] sync_assert_mask = 3'h0;
    slrs_lane_status_type lane_cmd = 32'h00000000;
    slrs_lane_status_type lane_status;
    slrs_link_cfg_type link_cfg;
    logic [7:0] reg_rdata;
    logic reg_rd_valid, sync_request_out, irq_n;
    int sync_cycles;
    int err_count = 0;
    int n_compared = 0;
    int cyc_cnt = 0;
    slrs_top slrs_top_inst (.core_clk(core_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .lane_status(lane_status),
        .sync_assert_mask(sync_assert_mask), .link_cfg(link_cfg),
        .sync_request_out(sync_request_out), .irq_n(irq_n));
    slrs_tx_model slrs_tx_model_inst (.core_clk(core_clk), .rst_n(rst_n), .lane_cmd(lane_cmd),
        .sync_request_out(sync_request_out), .lane_status(lane_status),
        .sync_cycles(sync_cycles));
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr_en = 1'b0;
    endtask : wr
    // Read data comes back exactly one cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e, input string name);
        @(negedge core_clk);
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(negedge core_clk);
        reg_rd_en = 1'b0;
        chk("rd_valid", 8'h01, {7'h00, reg_rd_valid});
        chk(name, e, reg_rdata);
    endtask : rd
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk("irq_n", 8'h01, {7'h00, irq_n});
        chk("sync_req", 8'h01, {7'h00, sync_request_out});
        // No lane aligned yet, so the request may not drop after release
        cyc(1);
        chk("sync_req", 8'h01, {7'h00, sync_request_out});
        rd(ADDR_LANE_INIT_SYNC_FLAGS, 8'h00, "sync_flags");
        rd(ADDR_FRAME_OCTET_COUNT, 8'h01, "frame_octets");
        rd(ADDR_LINK_TEST_CONTROL, 8'h00, "test_ctrl");
        rd(ADDR_ALIGNMENT_MULTIFRAME_COUNT, 8'h01, "multiframes");
        rd(ADDR_INTERRUPT_VECTOR, 8'h00, "vector");
        rd(12'h474, 8'h00, "unmapped");
        $display("t_reset done");
    endtask : t_reset
    task automatic t_cfg;
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_FRAME_OCTET_COUNT, 8'(i));
            chk("octets_valid", {7'h00, i == 1 || i == 2 || i == 4},
                {7'h00, link_cfg.octets_valid});
        end
        chk("octets_out", 8'h04, link_cfg.octets_per_frame);
        rd(ADDR_FRAME_OCTET_COUNT, 8'h04, "frame_octets");
        wr(ADDR_LINK_TEST_CONTROL, 8'hFF);
        rd(ADDR_LINK_TEST_CONTROL, 8'h88, "test_ctrl");
        // Threshold enable stays on for the sync mask scenario
        wr(ADDR_LINK_TEST_CONTROL, 8'h08);
        chk("test_mode", 8'h00, {7'h00, link_cfg.alignment_test_mode});
        chk("thresh_en", 8'h01, {7'h00, link_cfg.threshold_mask_en});
        wr(ADDR_ALIGNMENT_MULTIFRAME_COUNT, 8'hFF);
        chk("multiframes_out", 8'hFF, link_cfg.alignment_multiframes);
        rd(ADDR_ALIGNMENT_MULTIFRAME_COUNT, 8'hFF, "multiframes");
        wr(ADDR_DISP_LANES, 8'hFF);
        rd(ADDR_DISP_LANES, 8'h00, "disp_lanes");
        wr(12'h474, 8'h5A);
        rd(12'h474, 8'h00, "unmapped");
        $display("t_cfg done");
    endtask : t_cfg
    task automatic t_align;
        int sync_base;
        lane_cmd.align_ok = 8'hFF;
        cyc(3);
        chk("sync_req", 8'h00, {7'h00, sync_request_out});
        sync_base = sync_cycles;
        wr(ADDR_INTERRUPT_VECTOR, 8'h08);
        lane_cmd.align_ok = 8'hF7;
        cyc(3);
        chk("irq_n", 8'h00, {7'h00, irq_n});
        chk("sync_req", 8'h01, {7'h00, sync_request_out});
        rd(ADDR_LANE_INIT_SYNC_FLAGS, 8'hF7, "sync_flags");
        lane_cmd.align_ok = 8'hFF;
        cyc(3);
        rd(ADDR_INTERRUPT_VECTOR, 8'h08, "vector");
        chk("irq_n", 8'h00, {7'h00, irq_n});
        wr(ADDR_LANE_INIT_SYNC_FLAGS, 8'h80);
        rd(ADDR_INTERRUPT_VECTOR, 8'h00, "vector");
        cyc(2);
        chk("irq_n", 8'h01, {7'h00, irq_n});
        chk("sync_seen", 8'h01, {7'h00, sync_cycles > sync_base});
        wr(ADDR_INTERRUPT_VECTOR, 8'h00);
        $display("t_align done");
    endtask : t_align
    task automatic t_err;
        logic [7:0] bit_v;
        for (int k = 0; k < 3; k++) begin
            bit_v = 8'h80 >> k;
            lane_cmd[23-8*k -: 8] = 8'h24;
            rd(ADDR_INTERRUPT_VECTOR, bit_v, "vector");
            rd(ADDR_DISP_LANES + 12'(k), 8'h24, "lane_view");
            chk("irq_n", 8'h01, {7'h00, irq_n});
            wr(ADDR_INTERRUPT_VECTOR, bit_v);
            cyc(2);
            chk("irq_n", 8'h00, {7'h00, irq_n});
            // Each sync mask bit in turn, matching the active error kind
            sync_assert_mask = 3'h4 >> k;
            cyc(3);
            chk("sync_req", 8'h01, {7'h00, sync_request_out});
            sync_assert_mask = 3'h0;
            wr(ADDR_INTERRUPT_VECTOR, 8'h00);
            lane_cmd[23-8*k -: 8] = 8'h00;
            cyc(2);
            chk("irq_n", 8'h01, {7'h00, irq_n});
        end
        lane_cmd.disparity = 8'h01;
        sync_assert_mask = 3'h4;
        cyc(3);
        chk("sync_req", 8'h01, {7'h00, sync_request_out});
        sync_assert_mask = 3'h0;
        cyc(3);
        chk("sync_req", 8'h00, {7'h00, sync_request_out});
        lane_cmd.disparity = 8'h00;
        $display("t_err done");
    endtask : t_err
    ////////////////////////////////////////////////////////////////////////////
    // Tests need about 125 cycles; the ceiling of 3000 leaves wide margin
    always @(posedge core_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 3000) begin
            err_count++;
            $display("timeout reached");
            end_sim();
        end
    end
    initial begin
        repeat (8) @(negedge core_clk);
        rst_n = 1'b1;
        t_reset();
        t_cfg();
        t_align();
        t_err();
        end_sim();
    end
endmodule : testbench
